/* File: hdl/scmc_defs.vh */
/*
 Constants of the serial command-mode front end: timing, defaults, limits,
 binary opcodes, selector codes and register offsets.
 Assumes a 40 MHz clock.
*/
`ifndef SCMC_DEFS_VH
`define SCMC_DEFS_VH
`define SCMC_CLK_HZ 40000000
`define SCMC_UNIT_MS 100
`define SCMC_MS_PER_S 1000
`define SCMC_UNIT_CYCLES (`SCMC_CLK_HZ / `SCMC_MS_PER_S * `SCMC_UNIT_MS)
`define SCMC_SIL_MIN 16'h0002
`define SCMC_SIL_DEF 16'h000A
`define SCMC_SIL_SAT 16'hFFFF
`define SCMC_ESC_MIN 8'h20
`define SCMC_ESC_MAX 8'h7F
`define SCMC_ESC_DEF 8'h2B
`define SCMC_RATE_DEF 16'h0003
`define SCMC_RATE_STD_MAX 16'h0006
`define SCMC_RATE_NSTD_MIN 16'h007D
`define SCMC_OP_PRE 8'h04
`define SCMC_OP_POST 8'h05
`define SCMC_OP_EXIT 8'h09
`define SCMC_OP_RXSEL 8'h12
`define SCMC_OP_ESC 8'h13
`define SCMC_OP_RATE 8'h15
`define SCMC_OP_FLOW 8'h1F
`define SCMC_SEL_DEF 3'h0
`define SCMC_SEL_MAX 3'h4
`define SCMC_RX_LED 3'h0
`define SCMC_RX_HIGH 3'h1
`define SCMC_RX_LOW 3'h2
`define SCMC_RX_ADDR 3'h4
`define SCMC_FC_CTS 3'h0
`define SCMC_FC_TXEN_LO 3'h1
`define SCMC_FC_HIGH 3'h2
`define SCMC_FC_TXEN_HI 3'h3
`define SCMC_FC_LOW 3'h4
`define SCMC_A_PRE 8'h00
`define SCMC_A_POST 8'h04
`define SCMC_A_ESC 8'h08
`define SCMC_A_RXSEL 8'h0C
`define SCMC_A_FLOW 8'h10
`define SCMC_A_RATE 8'h14
`define SCMC_A_RATE_ACT 8'h18
`define SCMC_A_STATUS 8'h1C
`define SCMC_A_CTRL 8'h20
`define SCMC_A_NONE 8'hFF
`endif

/* File: hdl/scmc_top.v */
/*
 Serial command-mode front end: escape-sequence detection on the received
 byte stream, binary command parser, settings registers and the two
 configurable output lines.
 Assumes received bytes arrive as one-cycle strobes at least two cycles
 apart (true for any UART rate) and a plain register port master.
*/
`timescale 1ns/100ps
`include "scmc_defs.vh"

// Functional notes
// R01 - The pre-escape silence is programmable from 2 to 0xFFFF units of 100 ms and the line must be idle that long before the escape byte.
// R02 - After reset the pre-escape silence is 0x0A units, one second.
// R03 - The escape character accepts only 0x20 to 0x7F and resets to 0x2B.
// R04 - Command mode is entered only after pre-silence, escape byte and post-silence in that order.
// R05 - The post-escape silence is programmable from 0x02 to 0xFFFF units of 100 ms and resets to 0x0A.
// R06 - The exit command, code 0x09, leaves command mode at once for idle mode.
// R07 - A written serial rate stays pending until the exit command is processed.
// R08 - A non-standard rate request is stored as the nearest achievable value and queries return it.
// R09 - A command without a parameter is a query answered with the held value.
// R10 - The receive indicator follows its selector: 0 activity, 1 high, 2 low, 3 reserved, 4 addressed send.
// R11 - The flow-control line defaults to clear-to-send, is high for 2 and low for 4.
// R12 - Flow selector 1 or 3 makes the line a transmit enable, active low or high while sending.
// R13 - Binary codes 0x04, 0x13 and 0x1F select pre-silence, escape character and flow selector.
// R14 - Escape and selector queries answer one byte, the pre-silence query two bytes.
// R15 - A byte during a guard window restarts the silence and cancels the sequence, its bytes passing as data.
module scmc_top #(
   parameter UNIT_CYCLES = `SCMC_UNIT_CYCLES,
   parameter [15:0] RATE_DEFAULT = `SCMC_RATE_DEF
) (
   input wire clk,
   input wire reset,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr_en,
   input wire rd_en,
   output reg [31:0] rdata,
   input wire [7:0] serial_data_in,
   input wire serial_data_in_valid,
   output reg [7:0] data_out,
   output reg data_out_valid,
   output wire [7:0] resp_byte,
   output wire resp_valid,
   input wire resp_ready,
   input wire rx_activity,
   input wire addressed_tx,
   input wire host_rx_ready,
   input wire tx_active,
   output reg rx_indicator_line,
   output reg flow_control_line,
   output wire command_mode,
   output wire [15:0] serial_rate_setting
);
   localparam D_IDLE = 2'b00;
   localparam D_ESC = 2'b01;
   localparam D_CMD = 2'b10;
   localparam P_OP = 2'b00;
   localparam P_LEN = 2'b01;
   localparam P_PAR = 2'b10;
   localparam [31:0] UNIT_LAST = UNIT_CYCLES - 1;
   localparam [31:0] CLK_HZ = `SCMC_CLK_HZ;

   reg [15:0] pre_escape_silence_reg;
   reg [15:0] post_escape_silence_reg;
   reg [7:0] escape_character_reg;
   reg [2:0] rx_indicator_select_reg;
   reg [2:0] flow_select_reg;
   reg [15:0] rate_pending_reg;
   reg [15:0] serial_rate_setting_reg;
   reg [1:0] det_reg;
   reg [1:0] parse_reg;
   reg [7:0] op_reg;
   reg [1:0] len_reg;
   reg [7:0] val_hi_reg;
   reg [31:0] unit_cnt_reg;
   reg [15:0] silence_reg;
   reg [7:0] pend_reg;
   reg pend_valid_reg;
   reg [15:0] resp_data_reg;
   reg [1:0] resp_cnt_reg;

   reg [7:0] apply_addr;
   reg [15:0] apply_val;
   reg apply_ok;
   reg [7:0] query_addr;
   reg [1:0] query_len;
   reg [15:0] query_val;
   reg [31:0] rate_div;
   reg [31:0] rate_near;
   reg [15:0] rate_store;
   reg exit_req;
   reg ser_apply;
   reg ser_query;

   wire byte_in = serial_data_in_valid;
   wire pre_met = silence_reg >= pre_escape_silence_reg;
   wire post_met = silence_reg >= post_escape_silence_reg;
   wire in_cmd = det_reg == D_CMD;
   wire [15:0] par_val = {val_hi_reg, serial_data_in};

   assign command_mode = in_cmd;
   assign serial_rate_setting = serial_rate_setting_reg;
   assign resp_byte = resp_data_reg[15:8];
   assign resp_valid = resp_cnt_reg != 2'b00;

   function [7:0] op_to_addr;
      input [7:0] op;
      begin
         case (op)
            `SCMC_OP_PRE: op_to_addr = `SCMC_A_PRE; // R13
            `SCMC_OP_POST: op_to_addr = `SCMC_A_POST;
            `SCMC_OP_ESC: op_to_addr = `SCMC_A_ESC; // R13
            `SCMC_OP_RXSEL: op_to_addr = `SCMC_A_RXSEL;
            `SCMC_OP_FLOW: op_to_addr = `SCMC_A_FLOW; // R13
            `SCMC_OP_RATE: op_to_addr = `SCMC_A_RATE;
            default: op_to_addr = `SCMC_A_NONE;
         endcase
      end
   endfunction

   function [15:0] read_value;
      input [7:0] a;
      input [15:0] pre, post, rp, ra;
      input [7:0] esc;
      input [2:0] rxs, fls;
      input [1:0] det;
      begin
         case (a)
            `SCMC_A_PRE: read_value = pre;
            `SCMC_A_POST: read_value = post;
            `SCMC_A_ESC: read_value = {8'h00, esc};
            `SCMC_A_RXSEL: read_value = {13'h0000, rxs};
            `SCMC_A_FLOW: read_value = {13'h0000, fls};
            `SCMC_A_RATE: read_value = rp;
            `SCMC_A_RATE_ACT: read_value = ra;
            `SCMC_A_STATUS: read_value = {14'h0000, det};
            default: read_value = 16'h0000;
         endcase
      end
   endfunction

   // Nearest rate the clock can divide to; rounding both ways
   always @* begin
      rate_div = (CLK_HZ + {17'h00000, apply_val[15:1]}) / {16'h0000, apply_val};
      rate_near = (CLK_HZ + {1'b0, rate_div[31:1]}) / rate_div;
      rate_store = (apply_val <= `SCMC_RATE_STD_MAX) ? apply_val : rate_near[15:0]; // R08
   end

   // Exit, apply and query requests, decoded from the parser state and the bus control write
   always @* begin
      exit_req = 1'b0;
      ser_apply = 1'b0;
      ser_query = 1'b0;
      if (in_cmd && byte_in) begin
         case (parse_reg)
            P_OP: exit_req = serial_data_in == `SCMC_OP_EXIT; // R06
            P_LEN: ser_query = serial_data_in == 8'h00; // R09
            P_PAR: ser_apply = len_reg == 2'b01;
            default: ser_apply = 1'b0;
         endcase
      end
      if (wr_en && addr == `SCMC_A_CTRL && wdata[0])
         exit_req = 1'b1;
   end

   // One write path shared by the bus and the serial parser; bus first
   always @* begin
      if (wr_en) begin
         apply_addr = addr;
         apply_val = wdata[15:0];
      end else if (ser_apply) begin
         apply_addr = op_to_addr(op_reg);
         apply_val = par_val;
      end else begin
         apply_addr = `SCMC_A_NONE;
         apply_val = 16'h0000;
      end
      case (apply_addr)
         `SCMC_A_PRE, `SCMC_A_POST: apply_ok = apply_val >= `SCMC_SIL_MIN; // R01 R05
         `SCMC_A_ESC:
            apply_ok = apply_val >= {8'h00, `SCMC_ESC_MIN} &&
               apply_val <= {8'h00, `SCMC_ESC_MAX}; // R03
         `SCMC_A_RXSEL, `SCMC_A_FLOW: apply_ok = apply_val <= {13'h0000, `SCMC_SEL_MAX};
         `SCMC_A_RATE:
            apply_ok = apply_val <= `SCMC_RATE_STD_MAX ||
               apply_val >= `SCMC_RATE_NSTD_MIN;
         default: apply_ok = 1'b0;
      endcase
      query_addr = op_to_addr(op_reg);
      case (query_addr)
         `SCMC_A_ESC, `SCMC_A_RXSEL, `SCMC_A_FLOW: query_len = 2'b01; // R14
         `SCMC_A_NONE: query_len = 2'b00;
         default: query_len = 2'b10; // R14
      endcase
      query_val = read_value(query_addr, pre_escape_silence_reg, post_escape_silence_reg,
         rate_pending_reg, serial_rate_setting_reg, escape_character_reg,
         rx_indicator_select_reg, flow_select_reg, det_reg);
   end

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         pre_escape_silence_reg <= `SCMC_SIL_DEF; // R02
         post_escape_silence_reg <= `SCMC_SIL_DEF; // R05
         escape_character_reg <= `SCMC_ESC_DEF; // R03
         rx_indicator_select_reg <= `SCMC_SEL_DEF;
         flow_select_reg <= `SCMC_SEL_DEF;
         rate_pending_reg <= RATE_DEFAULT;
         serial_rate_setting_reg <= RATE_DEFAULT;
      end else begin
         if (apply_ok) begin
            case (apply_addr)
               `SCMC_A_PRE: pre_escape_silence_reg <= apply_val; // R01
               `SCMC_A_POST: post_escape_silence_reg <= apply_val; // R05
               `SCMC_A_ESC: escape_character_reg <= apply_val[7:0];
               `SCMC_A_RXSEL: rx_indicator_select_reg <= apply_val[2:0];
               `SCMC_A_FLOW: flow_select_reg <= apply_val[2:0];
               `SCMC_A_RATE: rate_pending_reg <= rate_store; // R07 R08
               default: rate_pending_reg <= rate_pending_reg;
            endcase
         end
         if (exit_req && in_cmd)
            serial_rate_setting_reg <= rate_pending_reg; // R07
      end
   end

   // Guard-time measurement; any received byte restarts it
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         unit_cnt_reg <= 32'h00000000;
         silence_reg <= 16'h0000;
      end else if (byte_in) begin
         unit_cnt_reg <= 32'h00000000; // R15
         silence_reg <= 16'h0000; // R15
      end else if (unit_cnt_reg >= UNIT_LAST) begin
         unit_cnt_reg <= 32'h00000000;
         if (silence_reg != `SCMC_SIL_SAT)
            silence_reg <= silence_reg + 16'h0001;
      end else begin
         unit_cnt_reg <= unit_cnt_reg + 32'h00000001;
      end
   end

   // Escape detector, data pass-through and command parser
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         det_reg <= D_IDLE;
         parse_reg <= P_OP;
         op_reg <= 8'h00;
         len_reg <= 2'b00;
         val_hi_reg <= 8'h00;
         pend_reg <= 8'h00;
         pend_valid_reg <= 1'b0;
         data_out <= 8'h00;
         data_out_valid <= 1'b0;
      end else begin
         data_out_valid <= 1'b0;
         if (pend_valid_reg) begin
            data_out <= pend_reg;
            data_out_valid <= 1'b1;
            pend_valid_reg <= 1'b0;
         end
         case (det_reg)
            D_IDLE: begin
               if (byte_in) begin
                  if (pre_met && serial_data_in == escape_character_reg) begin
                     det_reg <= D_ESC; // R01 R04
                     pend_reg <= serial_data_in;
                  end else begin
                     data_out <= serial_data_in;
                     data_out_valid <= 1'b1;
                  end
               end
            end
            D_ESC: begin
               if (byte_in) begin
                  // Held escape byte goes out now, the new byte next cycle
                  data_out <= pend_reg; // R15
                  data_out_valid <= 1'b1; // R15
                  pend_reg <= serial_data_in; // R15
                  pend_valid_reg <= 1'b1; // R15
                  det_reg <= D_IDLE; // R15
               end else if (post_met) begin
                  det_reg <= D_CMD; // R04 R05
                  parse_reg <= P_OP;
               end
            end
            D_CMD: begin
               if (exit_req) begin
                  det_reg <= D_IDLE; // R06
                  parse_reg <= P_OP;
               end else if (byte_in) begin
                  case (parse_reg)
                     P_OP: begin
                        op_reg <= serial_data_in;
                        parse_reg <= P_LEN;
                     end
                     P_LEN: begin
                        len_reg <= serial_data_in[1:0];
                        val_hi_reg <= 8'h00;
                        if (serial_data_in == 8'h01 || serial_data_in == 8'h02)
                           parse_reg <= P_PAR;
                        else
                           parse_reg <= P_OP;
                     end
                     P_PAR: begin
                        val_hi_reg <= serial_data_in;
                        len_reg <= len_reg - 2'b01;
                        if (len_reg == 2'b01)
                           parse_reg <= P_OP;
                     end
                     default: parse_reg <= P_OP;
                  endcase
               end
            end
            default: det_reg <= D_IDLE;
         endcase
      end
   end

   // Query answers leave most significant byte first
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         resp_data_reg <= 16'h0000;
         resp_cnt_reg <= 2'b00;
      end else if (ser_query && !resp_valid && query_len != 2'b00) begin
         resp_cnt_reg <= query_len; // R09 R14
         if (query_len == 2'b01)
            resp_data_reg <= {query_val[7:0], 8'h00}; // R14
         else
            resp_data_reg <= query_val; // R09 R08
      end else if (resp_valid && resp_ready) begin
         resp_cnt_reg <= resp_cnt_reg - 2'b01;
         resp_data_reg <= {resp_data_reg[7:0], 8'h00};
      end
   end

   // Register read port and output lines
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata <= 32'h00000000;
         rx_indicator_line <= 1'b0;
         flow_control_line <= 1'b0;
      end else begin
         if (rd_en)
            rdata <= {16'h0000, read_value(addr, pre_escape_silence_reg,
               post_escape_silence_reg, rate_pending_reg, serial_rate_setting_reg,
               escape_character_reg, rx_indicator_select_reg, flow_select_reg, det_reg)};
         else
            rdata <= 32'h00000000;
         case (rx_indicator_select_reg)
            `SCMC_RX_LED: rx_indicator_line <= rx_activity; // R10
            `SCMC_RX_HIGH: rx_indicator_line <= 1'b1; // R10
            `SCMC_RX_ADDR: rx_indicator_line <= addressed_tx; // R10
            default: rx_indicator_line <= 1'b0; // R10
         endcase
         case (flow_select_reg)
            // Clear-to-send is active low: high means stop
            `SCMC_FC_CTS: flow_control_line <= ~host_rx_ready; // R11
            `SCMC_FC_TXEN_LO: flow_control_line <= ~tx_active; // R12
            `SCMC_FC_HIGH: flow_control_line <= 1'b1; // R11
            `SCMC_FC_TXEN_HI: flow_control_line <= tx_active; // R12
            default: flow_control_line <= 1'b0; // R11
         endcase
      end
   end
endmodule // scmc_top

/* File: test/scmc_host_model.sv */
/* Host processor model on the received-byte side.
   Sends bytes, keeps guard silences, collects answer bytes. */
`timescale 1ns/100ps
module scmc_host_model #(
   parameter UNIT = 8
) (
   input wire clk,
   output reg [7:0] serial_data_in,
   output reg serial_data_in_valid,
   input wire [7:0] resp_byte,
   input wire resp_valid,
   output reg resp_ready
);
   reg [7:0] got_q[$];
   reg slow = 1'h0;
   reg [3:0] cyc_reg = 4'h0;
   initial begin
      serial_data_in = 8'h00;
      serial_data_in_valid = 1'h0;
      resp_ready = 1'h0;
   end
   // Slow mode stalls the answer every other pair of cycles
   always @(posedge clk) begin
      cyc_reg <= cyc_reg + 4'h1;
      resp_ready <= slow ? cyc_reg[1] : 1'h1;
      if (resp_valid && resp_ready)
         got_q.push_back(resp_byte);
   end
   // Released line shows the inverse, never a stale byte
   task send(input [7:0] b);
      begin
         @(posedge clk);
         serial_data_in <= b;
         serial_data_in_valid <= 1'h1;
         @(posedge clk);
         serial_data_in <= ~b;
         serial_data_in_valid <= 1'h0;
         @(posedge clk);
      end
   endtask
   task silence(input integer units);
      begin
         repeat (units * UNIT) @(posedge clk);
      end
   endtask
endmodule // scmc_host_model

/* File: test/scmc_top_assertions.sv */
/* Assertion checker for the serial command-mode front end.
   Sees only top-level ports; bound into scmc_top below. */
`timescale 1ns/100ps
`include "scmc_defs.vh"
module scmc_chk #(
   parameter UNIT_CYCLES = 8
) (
   input wire clk,
   input wire reset,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr_en,
   input wire rd_en,
   input wire [31:0] rdata,
   input wire serial_data_in_valid,
   input wire data_out_valid,
   input wire [7:0] resp_byte,
   input wire resp_valid,
   input wire resp_ready,
   input wire tx_active,
   input wire flow_control_line,
   input wire command_mode,
   input wire [15:0] serial_rate_setting
);
   reg [31:0] quiet_reg;
   reg [2:0] fsel_reg;
   // Selector tracked from bus writes only
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         quiet_reg <= 32'h0;
         fsel_reg <= 3'h0;
      end else begin
         if (serial_data_in_valid)
            quiet_reg <= 32'h0;
         else if (quiet_reg != 32'hFFFFFFFF)
            quiet_reg <= quiet_reg + 32'h1;
         if (wr_en && addr == `SCMC_A_FLOW && wdata[15:0] <= 16'h4)
            fsel_reg <= wdata[2:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   rdata_idle_a: assert property (!$past(rd_en) |-> rdata == 32'h0)
      else $error("read data not zero outside a read");
   ctrl_exit_a: assert property (wr_en && addr == `SCMC_A_CTRL && wdata[0] && command_mode
      |-> ##[1:2] !command_mode) else $error("exit did not leave command mode");
   rate_on_exit_a: assert property (!$stable(serial_rate_setting) |-> $fell(command_mode))
      else $error("rate changed outside exit");
   entry_silence_a: assert property ($rose(command_mode) |-> quiet_reg >= 2 * UNIT_CYCLES - 1)
      else $error("command mode entered without post silence");
   cmd_no_pass_a: assert property (command_mode && $past(command_mode) && serial_data_in_valid
      |=> !data_out_valid) else $error("command byte passed as data");
   pass_cause_a: assert property (data_out_valid
      |-> $past(serial_data_in_valid) || $past(serial_data_in_valid, 2))
      else $error("data out without received byte");
   resp_hold_a: assert property (resp_valid && !resp_ready |=> resp_valid && $stable(resp_byte))
      else $error("answer byte dropped while stalled");
   resp_in_cmd_a: assert property ($rose(resp_valid) |-> command_mode)
      else $error("answer outside command mode");
   txen_low_a: assert property (fsel_reg == 3'h1 |=> flow_control_line == !$past(tx_active))
      else $error("active-low transmit enable wrong");
   txen_high_a: assert property (fsel_reg == 3'h3 |=> flow_control_line == $past(tx_active))
      else $error("active-high transmit enable wrong");
   flow_static_a: assert property (fsel_reg == 3'h2 || fsel_reg == 3'h4
      |=> flow_control_line == ($past(fsel_reg) == 3'h2)) else $error("static flow level wrong");
endmodule // scmc_chk
bind scmc_top scmc_chk #(.UNIT_CYCLES(UNIT_CYCLES)) chk_u (.clk(clk), .reset(reset),
   .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
   .serial_data_in_valid(serial_data_in_valid), .data_out_valid(data_out_valid),
   .resp_byte(resp_byte), .resp_valid(resp_valid), .resp_ready(resp_ready),
   .tx_active(tx_active), .flow_control_line(flow_control_line),
   .command_mode(command_mode), .serial_rate_setting(serial_rate_setting));

/* File: test/tb.sv */
/* Self-checking bench for the serial command-mode front end.
   Register port driven here; serial side through the host model. */
`timescale 1ns/100ps
`include "scmc_defs.vh"
module tb;
   localparam U = 8;
   reg clk = 1'h0;
   reg reset = 1'h1;
   reg [7:0] addr = 8'h00;
   reg [31:0] wdata = 32'h0;
   reg wr_en = 1'h0;
   reg rd_en = 1'h0;
   reg rx_activity = 1'h0;
   reg addressed_tx = 1'h0;
   reg host_rx_ready = 1'h1;
   reg tx_active = 1'h0;
   wire [31:0] rdata;
   wire [7:0] sdi, data_out, resp_byte;
   wire sdi_v, data_out_valid, resp_valid, resp_ready, rx_ind, flow, cmd;
   wire [15:0] rate;
   integer err_total = 0;
   integer n_checks = 0;
   integer cyc = 0;
   reg [7:0] dq[$];
   always #12.5 clk = ~clk;
   scmc_top #(.UNIT_CYCLES(U)) dut_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .serial_data_in(sdi),
      .serial_data_in_valid(sdi_v), .data_out(data_out), .data_out_valid(data_out_valid),
      .resp_byte(resp_byte), .resp_valid(resp_valid), .resp_ready(resp_ready),
      .rx_activity(rx_activity), .addressed_tx(addressed_tx), .host_rx_ready(host_rx_ready),
      .tx_active(tx_active), .rx_indicator_line(rx_ind), .flow_control_line(flow),
      .command_mode(cmd), .serial_rate_setting(rate));
   scmc_host_model #(.UNIT(U)) host_u (.clk(clk), .serial_data_in(sdi),
      .serial_data_in_valid(sdi_v), .resp_byte(resp_byte), .resp_valid(resp_valid),
      .resp_ready(resp_ready));
   always @(posedge clk) begin
      if (data_out_valid)
         dq.push_back(data_out);
   end
   task chk(input [8*8-1:0] nm, input [31:0] got, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("wrong value %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] v);
      begin
         @(posedge clk);
         wr_en <= 1'h1;
         addr <= a;
         wdata <= v;
         @(posedge clk);
         wr_en <= 1'h0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] exp);
      begin
         @(posedge clk);
         rd_en <= 1'h1;
         addr <= a;
         @(posedge clk);
         rd_en <= 1'h0;
         #1;
         chk("rdata", rdata, exp);
      end
   endtask
   task settle(input [7:0] a, input [31:0] v);
      begin
         wr(a, v);
         repeat (2) @(posedge clk);
         #1;
      end
   endtask
   task enter_cmd;
      begin
         host_u.silence(3);
         host_u.send(`SCMC_ESC_DEF);
         host_u.silence(3);
      end
   endtask
   task t_defaults;
      begin
         rd(`SCMC_A_PRE, 32'hA);
         rd(`SCMC_A_POST, 32'hA);
         rd(`SCMC_A_ESC, 32'h2B);
         rd(`SCMC_A_RXSEL, 32'h0);
         rd(`SCMC_A_FLOW, 32'h0);
         rd(`SCMC_A_NONE, 32'h0);
         rd(`SCMC_A_RATE_ACT, 32'h3);
      end
   endtask
   task t_limits;
      begin
         wr(`SCMC_A_ESC, 32'h1F);
         wr(`SCMC_A_ESC, 32'h80);
         rd(`SCMC_A_ESC, 32'h2B);
         wr(`SCMC_A_ESC, 32'h7F);
         rd(`SCMC_A_ESC, 32'h7F);
         wr(`SCMC_A_ESC, 32'h20);
         rd(`SCMC_A_ESC, 32'h20);
         wr(`SCMC_A_ESC, 32'h2B);
         wr(`SCMC_A_PRE, 32'h1);
         rd(`SCMC_A_PRE, 32'hA);
         wr(`SCMC_A_PRE, 32'hFFFF);
         rd(`SCMC_A_PRE, 32'hFFFF);
         wr(`SCMC_A_PRE, 32'h2);
         wr(`SCMC_A_POST, 32'h2);
         rd(`SCMC_A_POST, 32'h2);
      end
   endtask
   task t_escape;
      begin
         host_u.silence(3);
         host_u.send(8'h41);
         host_u.send(8'h2B);
         host_u.silence(3);
         chk("cmd", cmd, 1'h0);
         host_u.send(8'h2B);
         host_u.send(8'h55);
         host_u.silence(3);
         chk("cmd", cmd, 1'h0);
         chk("data", {dq[0], dq[1], dq[2], dq[3]}, 32'h412B2B55);
         dq.delete();
         enter_cmd();
         chk("cmd", cmd, 1'h1);
         chk("ndata", dq.size(), 0);
         rd(`SCMC_A_STATUS, 32'h2);
         wr(`SCMC_A_CTRL, 32'h1);
         @(posedge clk);
         #1;
         chk("cmd", cmd, 1'h0);
         chk("rate", rate, 16'h3);
      end
   endtask
   task t_cmds;
      begin
         enter_cmd();
         host_u.send(`SCMC_OP_ESC);
         host_u.send(8'h00);
         repeat (6) @(posedge clk);
         chk("nesc", host_u.got_q.size(), 1);
         chk("esc", host_u.got_q[0], 8'h2B);
         host_u.got_q.delete();
         host_u.slow = 1'h1;
         host_u.send(`SCMC_OP_PRE);
         host_u.send(8'h00);
         repeat (20) @(posedge clk);
         chk("npre", host_u.got_q.size(), 2);
         chk("pre", {host_u.got_q[0], host_u.got_q[1]}, 16'h0002);
         host_u.got_q.delete();
         host_u.send(`SCMC_OP_FLOW);
         host_u.send(8'h01);
         host_u.send(8'h02);
         rd(`SCMC_A_FLOW, 32'h2);
         host_u.send(`SCMC_OP_RATE);
         host_u.send(8'h02);
         host_u.send(8'hE1);
         host_u.send(8'h00);
         chk("rate", rate, 16'h3);
         host_u.send(`SCMC_OP_RATE);
         host_u.send(8'h00);
         repeat (20) @(posedge clk);
         // E100 requested; a 40 MHz divider of 694 gives E125
         chk("rate_q", {host_u.got_q[0], host_u.got_q[1]}, 16'hE125);
         host_u.send(`SCMC_OP_EXIT);
         chk("cmd", cmd, 1'h0);
         chk("rate", rate, 16'hE125);
         rd(`SCMC_A_RATE_ACT, 32'hE125);
      end
   endtask
   task t_lines;
      begin
         @(posedge clk);
         tx_active <= 1'h1;
         addressed_tx <= 1'h1;
         settle(`SCMC_A_RXSEL, 32'h1);
         chk("rxl", rx_ind, 1'h1);
         settle(`SCMC_A_RXSEL, 32'h2);
         chk("rxl", rx_ind, 1'h0);
         settle(`SCMC_A_RXSEL, 32'h4);
         chk("rxl", rx_ind, 1'h1);
         settle(`SCMC_A_FLOW, 32'h2);
         chk("flow", flow, 1'h1);
         settle(`SCMC_A_FLOW, 32'h4);
         chk("flow", flow, 1'h0);
         settle(`SCMC_A_FLOW, 32'h1);
         chk("flow", flow, 1'h0);
         settle(`SCMC_A_FLOW, 32'h3);
         chk("flow", flow, 1'h1);
         @(posedge clk);
         tx_active <= 1'h0;
         addressed_tx <= 1'h0;
         settle(`SCMC_A_FLOW, 32'h5);
         chk("flow", flow, 1'h0);
         chk("rxl", rx_ind, 1'h0);
         rd(`SCMC_A_FLOW, 32'h3);
         settle(`SCMC_A_FLOW, 32'h1);
         chk("flow", flow, 1'h1);
         @(posedge clk);
         rx_activity <= 1'h1;
         addressed_tx <= 1'h1;
         host_rx_ready <= 1'h0;
         settle(`SCMC_A_RXSEL, 32'h3);
         chk("rxl", rx_ind, 1'h0);
         settle(`SCMC_A_RXSEL, 32'h0);
         chk("rxl", rx_ind, 1'h1);
         settle(`SCMC_A_FLOW, 32'h0);
         chk("flow", flow, 1'h1);
         @(posedge clk);
         rx_activity <= 1'h0;
         host_rx_ready <= 1'h1;
         repeat (2) @(posedge clk);
         #1;
         chk("flow", flow, 1'h0);
         chk("rxl", rx_ind, 1'h0);
      end
   endtask
   task stop_test;
      begin
         if (err_total == 0 && n_checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   // Ceiling far above the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         stop_test;
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'h0;
      t_defaults;
      t_limits;
      t_escape;
      t_cmds;
      t_lines;
      stop_test;
   end
endmodule // tb
